// ### ude_endpoint_status.sv
`timescale 1ns/100ps
`include "ude_map.svh"

module ude_endpoint_status #(
  parameter int DEPTH_LOG2 = 6
) (
  // Clock and reset
  input  wire logic                    mclk_i,
  input  wire logic                    rst_n_i,
  // Register port
  input  wire logic [`UDE_AW-1:0]      reg_addr_i,
  input  wire logic [7:0]              reg_wdata_i,
  input  wire logic                    reg_wr_i,
  input  wire logic                    reg_rd_i,
  output logic      [7:0]              reg_rdata_o,
  // Serial engine, transmit side
  input  ude_pkg::ude_tx_ev_t          tx_ev_i,
  output ude_pkg::ude_tx_ctl_t         tx_ctl_o,
  // Serial engine, receive side
  input  ude_pkg::ude_rx_ev_t          rx_ev_i,
  input  wire logic [DEPTH_LOG2:0]     rx_level_i,
  input  wire logic                    frame_lsb_i,
  // Warning event to the event logic
  output logic                         tx_low_warn_o
);
  import ude_pkg::*;

  localparam int PW    = DEPTH_LOG2 + 1;
  localparam int DEPTH = 1 << DEPTH_LOG2;

  ude_tx_state_t st_q, st_d;
  logic [PW-1:0] wp_q, wp_d, rp_q, rp_d, save_q, save_d;
  logic          arm_q, arm_d, fin_q, fin_d, tog_q, tog_d;
  logic          flush_q, flush_d, refill_q, refill_d, ign_q, ign_d;
  logic [1:0]    wlvl_q, wlvl_d;
  logic          done_q, done_d, ack_q, ack_d, urun_q, urun_d;
  logic          go_d, stall_d, ferr_d;
  logic          iso_q, stallcfg_q, warn_q;
  logic [7:0]    mem [DEPTH];
  logic [7:0]    rdata_q;
  ude_tx_ctl_t   ctl_q;
  ude_rx_stat_t  rxm_q, rxm_d, rxs_q, rxs_d, rx_new;
  logic          secv_q, secv_d, zlp_q, zlp_d;

  // Strobe decode for one register
  function automatic logic hit(input logic [`UDE_AW-1:0] a,
                               input logic stb,
                               input logic [`UDE_AW-1:0] target);
    hit = stb && (a == target);
  endfunction : hit

  // Access decode
  wire wr_txc = hit(reg_addr_i, reg_wr_i, `UDE_A_TXCMD);
  wire wr_txd = hit(reg_addr_i, reg_wr_i, `UDE_A_TXDATA);
  wire wr_cfg = hit(reg_addr_i, reg_wr_i, `UDE_A_EPCFG);
  wire rd_txs = hit(reg_addr_i, reg_rd_i, `UDE_A_TXSTAT);
  wire rd_rxs = hit(reg_addr_i, reg_rd_i, `UDE_A_RXSTAT);
  wire rd_wev = hit(reg_addr_i, reg_rd_i, `UDE_A_WARNEV);

  // FIFO fill state
  wire [PW-1:0] bytes  = wp_q - rp_q;
  wire [PW-1:0] free   = PW'(DEPTH) - bytes;
  wire          empty  = (bytes == '0);
  wire          full   = (bytes == PW'(DEPTH));
  wire [4:0]    free_s = (free > PW'(`UDE_TX_FREE_MAX)) ? `UDE_TX_FREE_MAX : free[4:0];

  wire lsb_match = (frame_lsb_i == tog_q);
  wire tx_ok     = !iso_q || ign_q || lsb_match;
  wire [7:0] wd  = reg_wdata_i;

  // Transmit control next state
  always_comb begin
    st_d     = st_q;
    wp_d     = wp_q;
    rp_d     = rp_q;
    save_d   = save_q;
    arm_d    = arm_q;
    fin_d    = fin_q;
    tog_d    = tog_q;
    flush_d  = flush_q;
    refill_d = refill_q;
    ign_d    = ign_q;
    wlvl_d   = wlvl_q;
    done_d   = done_q;
    ack_d    = ack_q;
    urun_d   = urun_q;
    go_d     = 1'b0;
    stall_d  = 1'b0;
    ferr_d   = 1'b0;
    // Clear on status read; later sets override
    if (rd_txs) begin
      done_d = 1'b0;
      ack_d  = 1'b0;
      urun_d = 1'b0;
    end
    // Payload bytes only enter the FIFO
    if (wr_txd && !full) begin
      wp_d = wp_q + 1'b1;
    end
    unique case (st_q)
      UDE_ST_IDLE: begin
        if (tx_ev_i.in_tok && stallcfg_q) begin
          stall_d = 1'b1;
          done_d  = 1'b1;
          arm_d   = 1'b0;
        end else if (tx_ev_i.in_tok && arm_q && tx_ok) begin
          go_d = 1'b1;
          st_d = UDE_ST_SEND;
        end else if (tx_ev_i.sof && iso_q && !ign_q && arm_q && lsb_match) begin
          done_d = 1'b1;
          ack_d  = 1'b0;
          arm_d  = 1'b0;
          fin_d  = 1'b0;
          wp_d   = '0;
          rp_d   = '0;
        end
      end
      UDE_ST_SEND, UDE_ST_ABORT: begin
        if (tx_ev_i.pop && !empty) begin
          rp_d = rp_q + 1'b1;
        end else if (tx_ev_i.pop && !fin_q && st_q == UDE_ST_SEND) begin
          urun_d = 1'b1;
          ferr_d = 1'b1;
          st_d   = UDE_ST_ABORT;
        end
        if (tx_ev_i.eop) begin
          arm_d = 1'b0;
          fin_d = 1'b0;
          if (iso_q) begin
            done_d = 1'b1;
            ack_d  = (st_q == UDE_ST_SEND);
            st_d   = UDE_ST_IDLE;
          end else begin
            st_d = UDE_ST_HS;
          end
        end
      end
      UDE_ST_HS: begin
        if (tx_ev_i.host_ack || tx_ev_i.host_noack) begin
          done_d = 1'b1;
          ack_d  = tx_ev_i.host_ack;
          st_d   = UDE_ST_IDLE;
        end
      end
      default: begin
        st_d = UDE_ST_IDLE;
      end
    endcase
    if (flush_q && st_q == UDE_ST_IDLE) begin
      wp_d    = '0;
      rp_d    = '0;
      flush_d = 1'b0;
    end
    if (refill_q && st_q == UDE_ST_IDLE) begin
      rp_d     = save_q;
      refill_d = 1'b0;
    end
    // Firmware command write
    if (wr_txc) begin
      arm_d  = wd[`UDE_TC_ARM];
      fin_d  = wd[`UDE_TC_FINAL];
      tog_d  = wd[`UDE_TC_TOG];
      ign_d  = wd[`UDE_TC_IGN];
      wlvl_d = {wd[`UDE_TC_WARN_HI], wd[`UDE_TC_WARN_LO]};
      if (wd[`UDE_TC_FINAL] && !fin_q) begin
        save_d = rp_q;
      end
      if (wd[`UDE_TC_FLUSH]) begin
        flush_d = 1'b1;
      end
      if (wd[`UDE_TC_REFILL]) begin
        refill_d = 1'b1;
      end
    end
  end

  // Transmit state registers
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st_q   <= UDE_ST_IDLE;
      wp_q   <= '0;
      rp_q   <= '0;
      save_q <= '0;
    end else begin
      st_q   <= st_d;
      wp_q   <= wp_d;
      rp_q   <= rp_d;
      save_q <= save_d;
    end
  end

  // Command and status bits
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      {arm_q, fin_q, tog_q, flush_q, refill_q, ign_q} <= '0;
      wlvl_q                   <= `UDE_WL_OFF;
      {done_q, ack_q, urun_q}  <= '0;
    end else begin
      {arm_q, fin_q, tog_q}    <= {arm_d, fin_d, tog_d};
      {flush_q, refill_q}      <= {flush_d, refill_d};
      ign_q                    <= ign_d;
      wlvl_q                   <= wlvl_d;
      {done_q, ack_q, urun_q}  <= {done_d, ack_d, urun_d};
    end
  end

  // FIFO storage
  always_ff @(posedge mclk_i) begin
    if (wr_txd && !full) begin
      mem[wp_q[DEPTH_LOG2-1:0]] <= wd;
    end
  end

  // Warning threshold select
  // Level decode
  wire [7:0] thr = (wlvl_q == `UDE_WL_4) ? `UDE_WARN_4 :
                   (wlvl_q == `UDE_WL_8) ? `UDE_WARN_8 : `UDE_WARN_16;
  wire warn_set  = arm_q && (wlvl_q != `UDE_WL_OFF) && (bytes <= PW'(thr));

  // Endpoint configuration and warning event
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      iso_q      <= 1'b0;
      stallcfg_q <= 1'b0;
      warn_q     <= 1'b0;
    end else begin
      if (wr_cfg) begin
        iso_q      <= wd[`UDE_CF_ISO];
        stallcfg_q <= wd[`UDE_CF_STALL];
      end
      warn_q <= warn_set || (warn_q && !rd_wev);
    end
  end

  // Controls to the serial engine
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ctl_q <= '0;
    end else begin
      ctl_q.go        <= go_d;
      ctl_q.stall     <= stall_d;
      ctl_q.pid1      <= tog_d && !iso_q;
      ctl_q.avail     <= (wp_d != rp_d);
      ctl_q.pkt_final <= fin_d;
      ctl_q.force_err <= ferr_d;
      ctl_q.data      <= mem[rp_d[DEPTH_LOG2-1:0]];
    end
  end

  // New receive status from a good packet
  always_comb begin
    rx_new       = '0;
    rx_new.last  = 1'b1;
    rx_new.setup = rx_ev_i.setup;
    rx_new.tog   = iso_q ? frame_lsb_i : rx_ev_i.pid1;
  end

  // Receive status copies
  always_comb begin
    rxm_d  = rxm_q;
    rxs_d  = rxs_q;
    secv_d = secv_q;
    zlp_d  = zlp_q;
    if (rd_rxs) begin
      rxm_d  = secv_q ? rxs_q : '0;
      secv_d = 1'b0;
      zlp_d  = 1'b0;
    end
    if (rx_ev_i.good) begin
      if (rx_ev_i.setup && !rx_ev_i.zero_len && zlp_q && !rd_rxs) begin
        rxs_d  = rx_new;
        secv_d = 1'b1;
      end else begin
        rxm_d.last  = 1'b1;
        rxm_d.setup = rxm_d.setup || rx_new.setup;
        rxm_d.tog   = rx_new.tog;
        zlp_d       = rx_ev_i.zero_len;
      end
    end
    if (rx_ev_i.err) begin
      rxm_d.err = 1'b1;
    end
  end

  // Receive status registers
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rxm_q  <= '0;
      rxs_q  <= '0;
      secv_q <= 1'b0;
      zlp_q  <= 1'b0;
    end else begin
      rxm_q  <= rxm_d;
      rxs_q  <= rxs_d;
      secv_q <= secv_d;
      zlp_q  <= zlp_d;
    end
  end

  wire [3:0] rx_cnt = (rx_level_i > PW'(`UDE_RX_CNT_MAX)) ? `UDE_RX_CNT_MAX
                                                         : rx_level_i[3:0];

  // Read data images
  wire [7:0] txs_img = {urun_q, ack_q, done_q, free_s};
  wire [7:0] txc_img = {ign_q, wlvl_q, refill_q, flush_q, tog_q, fin_q, arm_q};
  wire [7:0] rxs_img = {rxm_q.err, rxm_q.setup, rxm_q.tog, rxm_q.last, rx_cnt};
  wire [7:0] cfg_img = {6'h00, stallcfg_q, iso_q};
  wire [7:0] wev_img = {7'h00, warn_q};
  wire [7:0] rd_mux  = (reg_addr_i == `UDE_A_TXSTAT) ? txs_img :
                       (reg_addr_i == `UDE_A_TXCMD)  ? txc_img :
                       (reg_addr_i == `UDE_A_RXSTAT) ? rxs_img :
                       (reg_addr_i == `UDE_A_EPCFG)  ? cfg_img :
                       (reg_addr_i == `UDE_A_WARNEV) ? wev_img : `UDE_RST_BYTE;

  // Read data for one cycle after the strobe
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rdata_q <= `UDE_RST_BYTE;
    end else begin
      rdata_q <= reg_rd_i ? rd_mux : `UDE_RST_BYTE;
    end
  end

  assign reg_rdata_o   = rdata_q;
  assign tx_ctl_o      = ctl_q;
  assign tx_low_warn_o = warn_q;

endmodule : ude_endpoint_status

// ### ude_map.svh
`ifndef UDE_MAP_SVH
`define UDE_MAP_SVH

// Register port address width and offsets
`define UDE_AW          3
`define UDE_A_TXSTAT    3'h0
`define UDE_A_TXCMD     3'h1
`define UDE_A_TXDATA    3'h2
`define UDE_A_RXSTAT    3'h3
`define UDE_A_EPCFG     3'h4
`define UDE_A_WARNEV    3'h5

// Transmit status fields
`define UDE_TS_URUN     7
`define UDE_TS_ACK      6
`define UDE_TS_DONE     5
`define UDE_TX_FREE_MAX 5'h1f

// Transmit command fields
`define UDE_TC_ARM      0
`define UDE_TC_FINAL    1
`define UDE_TC_TOG      2
`define UDE_TC_FLUSH    3
`define UDE_TC_REFILL   4
`define UDE_TC_WARN_LO  5
`define UDE_TC_WARN_HI  6
`define UDE_TC_IGN      7

// Warning level codes and thresholds
`define UDE_WL_OFF      2'h0
`define UDE_WL_4        2'h1
`define UDE_WL_8        2'h2
`define UDE_WL_16       2'h3
`define UDE_WARN_4      8'h04
`define UDE_WARN_8      8'h08
`define UDE_WARN_16     8'h10

// Receive status saturation
`define UDE_RX_CNT_MAX  4'hf

// Endpoint configuration fields
`define UDE_CF_ISO      0
`define UDE_CF_STALL    1

// Warning event field
`define UDE_WE_TXLOW    0

// Reset values
`define UDE_RST_BYTE    8'h00

`endif

// ### ude_pkg.sv
package ude_pkg;

  // Transmit state machine, one-hot
  typedef enum logic [3:0] {
    UDE_ST_IDLE  = 4'b0001,
    UDE_ST_SEND  = 4'b0010,
    UDE_ST_ABORT = 4'b0100,
    UDE_ST_HS    = 4'b1000
  } ude_tx_state_t;

  // Events from the serial engine for the transmit endpoint
  typedef struct packed {
    logic in_tok;
    logic pop;
    logic eop;
    logic host_ack;
    logic host_noack;
    logic sof;
  } ude_tx_ev_t;

  // Controls and data to the serial engine
  typedef struct packed {
    logic       go;
    logic       stall;
    logic       pid1;
    logic       avail;
    logic       pkt_final;
    logic       force_err;
    logic [7:0] data;
  } ude_tx_ctl_t;

  // Events from the serial engine for the receive endpoint
  typedef struct packed {
    logic good;
    logic err;
    logic setup;
    logic pid1;
    logic zero_len;
  } ude_rx_ev_t;

  // One copy of receive status flags
  typedef struct packed {
    logic err;
    logic setup;
    logic tog;
    logic last;
  } ude_rx_stat_t;

endpackage : ude_pkg

// ### ude_endpoint_status_sva.sv
`timescale 1ns/100ps
`include "ude_map.svh"
// Port-level checks of the endpoint status block
module ude_endpoint_status_sva #(
  parameter int DEPTH_LOG2 = 6
) (
  // Clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 rst_n_i,
  // Register port
  input  wire logic [`UDE_AW-1:0]   reg_addr_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  input  wire logic [7:0]           reg_rdata_o,
  // Serial engine side
  input  ude_pkg::ude_tx_ev_t       tx_ev_i,
  input  ude_pkg::ude_tx_ctl_t      tx_ctl_o,
  input  wire logic [DEPTH_LOG2:0]  rx_level_i,
  // Warning event output
  input  wire logic                 tx_low_warn_o
);
  import ude_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // Read data stands only in the slot after a read
  rd_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data outside its slot");
  unmap_rd_a: assert property (reg_rd_i && reg_addr_i > 3'h5 |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  rx_count_a: assert property (reg_rd_i && reg_addr_i == `UDE_A_RXSTAT |=>
    reg_rdata_o[3:0] == ($past(rx_level_i) > 15 ? 4'hf : 4'($past(rx_level_i))))
    else $error("receive count wrong");
  // Warning event register mirrors the warning output
  warn_read_a: assert property (reg_rd_i && reg_addr_i == `UDE_A_WARNEV |=>
    reg_rdata_o == {7'h00, $past(tx_low_warn_o)})
    else $error("warning event image differs from output");
  // Transmit answers follow their causes
  go_cause_a: assert property (tx_ctl_o.go |-> $past(tx_ev_i.in_tok))
    else $error("send start without IN token");
  stall_cause_a: assert property (tx_ctl_o.stall |-> $past(tx_ev_i.in_tok) && !tx_ctl_o.go)
    else $error("stall without IN token");
  urun_cause_a: assert property (tx_ctl_o.force_err |->
    $past(tx_ev_i.pop) && !$past(tx_ctl_o.avail))
    else $error("forced error without empty pop");
  go_once_a: assert property (tx_ctl_o.go |=> !tx_ctl_o.go [*3])
    else $error("second send start in one packet");
  final_hold_a: assert property ($fell(tx_ctl_o.pkt_final) |->
    $past(tx_ev_i.eop) || $past(reg_wr_i) || $past(tx_ev_i.sof))
    else $error("final mark dropped early");
  // Main scenarios reached
  go_c: cover property (tx_ctl_o.go);
  stall_c: cover property (tx_ctl_o.stall);
  urun_c: cover property (tx_ctl_o.force_err);
  warn_c: cover property ($rose(tx_low_warn_o));
endmodule : ude_endpoint_status_sva

// ### ude_eng_model.sv
`timescale 1ns/100ps
// Serial engine stand-in on the far side of the endpoint
module ude_eng_model (
  // Clock
  input  wire logic            mclk_i,
  // Endpoint side
  input  ude_pkg::ude_tx_ctl_t ctl_i,
  output ude_pkg::ude_tx_ev_t  tx_ev_o,
  output ude_pkg::ude_rx_ev_t  rx_ev_o,
  output logic [6:0]           rx_level_o,
  output logic                 frame_lsb_o,
  // Observed answers
  output logic [8:0]           obs_o,
  output logic                 obs_v_o
);
  import ude_pkg::*;
  // Quiet engine at start
  initial begin
    tx_ev_o = '0;
    rx_ev_o = '0;
    rx_level_o = '0;
    frame_lsb_o = 1'b0;
    obs_o = '0;
    obs_v_o = 1'b0;
  end
  // One-cycle transmit event
  task automatic pulse(input ude_tx_ev_t e);
    @(posedge mclk_i) tx_ev_o <= e;
    @(posedge mclk_i) tx_ev_o <= '0;
  endtask : pulse
  // Emit one observation
  task automatic note(input logic [8:0] v);
    obs_o <= v;
    obs_v_o <= 1'b1;
    @(posedge mclk_i) obs_v_o <= 1'b0;
  endtask : note
  // IN transaction: n pops, then handshake hs (0 none, 1 ack, 2 no ack)
  task automatic in_xfer(input int n, input int hs);
    logic go;
    pulse('{in_tok: 1'b1, default: 1'b0});
    @(posedge mclk_i);
    go = ctl_i.go;
    note(go ? {8'h80, ctl_i.pid1} : (ctl_i.stall ? 9'h1f0 : 9'h1ff));
    if (go) begin
      repeat (n) begin
        @(posedge mclk_i);
        tx_ev_o.pop <= 1'b1;
        note(ctl_i.avail ? {1'b0, ctl_i.data} : 9'h1ee);
        tx_ev_o.pop <= 1'b0;
        @(posedge mclk_i);
      end
      pulse('{eop: 1'b1, default: 1'b0});
      if (hs != 0)
        pulse('{host_ack: hs == 1, host_noack: hs == 2, default: 1'b0});
    end
    repeat (3) @(posedge mclk_i);
  endtask : in_xfer
  // Received packet event with FIFO level
  task automatic rx(input ude_rx_ev_t e, input logic [6:0] lvl);
    @(posedge mclk_i);
    rx_ev_o <= e;
    rx_level_o <= lvl;
    @(posedge mclk_i) rx_ev_o <= '0;
    repeat (2) @(posedge mclk_i);
  endtask : rx
  // Frame number LSB change
  task automatic frame(input logic b);
    @(posedge mclk_i) frame_lsb_o <= b;
  endtask : frame
endmodule : ude_eng_model

// ### tb.sv
`timescale 1ns/100ps
module tb;
  import ude_pkg::*;
  logic        mclk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [2:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic [7:0]  reg_rdata_o;
  ude_tx_ev_t  tx_ev_i;
  ude_tx_ctl_t tx_ctl_o;
  ude_rx_ev_t  rx_ev_i;
  logic [6:0]  rx_level_i;
  logic        frame_lsb_i;
  logic        tx_low_warn_o;
  logic [8:0]  obs;
  logic        obs_v;
  logic        rd_q = 1'b0;
  logic [7:0]  rq[$];
  logic [8:0]  eq[$];
  logic [7:0]  pk[$];
  int          err_count = 0;
  int          check_count = 0;

  ude_endpoint_status dut (.mclk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .tx_ev_i, .tx_ctl_o, .rx_ev_i, .rx_level_i, .frame_lsb_i,
    .tx_low_warn_o);
  ude_eng_model eng (.mclk_i, .ctl_i(tx_ctl_o), .tx_ev_o(tx_ev_i), .rx_ev_o(rx_ev_i),
    .rx_level_o(rx_level_i), .frame_lsb_o(frame_lsb_i), .obs_o(obs), .obs_v_o(obs_v));

  // 40 MHz clock
  always #12.5 mclk_i = ~mclk_i;

  task automatic chk(input logic [8:0] seen, input logic [8:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic test_done;
    if (rq.size() + eq.size() != 0)
      err_count++;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i) reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    rq.push_back(e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i) reg_rd_i <= 1'b0;
  endtask : rd
  // Random payload into the transmit data port
  task automatic put(input int n);
    logic [7:0] b;
    pk.delete();
    repeat (n) begin
      b = 8'($urandom);
      pk.push_back(b);
      wr(3'h2, b);
    end
  endtask : put
  // Expected send start with PID, then the payload
  task automatic exp_pkt(input logic pid);
    eq.push_back({8'h80, pid});
    foreach (pk[i]) eq.push_back({1'b0, pk[i]});
  endtask : exp_pkt

  // Compare outputs with the oldest note
  always @(posedge mclk_i) begin
    rd_q <= reg_rd_i;
    if (rd_q)
      chk({1'b0, reg_rdata_o}, {1'b0, rq.pop_front()}, "register");
    if (obs_v)
      chk(obs, eq.pop_front(), "engine");
  end

  // Hang guard
  initial begin
    #(25 * 6000);
    err_count++;
    test_done;
  end

  // Main sequence
  initial begin
    int k;
    logic [7:0] c;
    reg_addr_i  = '0;
    reg_wdata_i = '0;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    k = $urandom(73305);
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    for (k = 0; k < 8; k++)
      if (k != 2) rd(3'(k), k == 0 ? 8'h1f : 8'h00);
    for (k = 0; k < 4; k++) begin
      c = {1'b0, 2'(k), 2'b00, k[0], 2'b00};
      wr(3'h1, c);
      put(k == 0 ? 3 : (4 << (k - 1)) + 2);
      rd(3'h5, 8'h00);
      wr(3'h1, c | 8'h03);
      exp_pkt(k[0]);
      eng.in_xfer(pk.size(), k == 2 ? 2 : 1);
      rd(3'h5, k == 0 ? 8'h00 : 8'h01);
      rd(3'h0, k == 2 ? 8'h3f : 8'h7f);
      rd(3'h0, 8'h1f);
      rd(3'h1, c);
    end
    put(2);
    wr(3'h1, 8'h03);
    exp_pkt(1'b0);
    eng.in_xfer(2, 2);
    wr(3'h1, 8'h10);
    rd(3'h1, 8'h00);
    wr(3'h1, 8'h03);
    exp_pkt(1'b0);
    eng.in_xfer(2, 1);
    rd(3'h0, 8'h7f);
    put(1);
    wr(3'h1, 8'h01);
    exp_pkt(1'b0);
    eq.push_back(9'h1ee);
    eng.in_xfer(2, 2);
    rd(3'h0, 8'hbf);
    put(3);
    wr(3'h1, 8'h08);
    rd(3'h1, 8'h00);
    put(2);
    wr(3'h1, 8'h03);
    exp_pkt(1'b0);
    eng.in_xfer(2, 1);
    rd(3'h0, 8'h7f);
    // stall, status kept over other accesses
    wr(3'h4, 8'h02);
    wr(3'h1, 8'h01);
    eq.push_back(9'h1f0);
    eng.in_xfer(0, 0);
    wr(3'h0, 8'h00);
    rd(3'h3, 8'h00);
    rd(3'h0, 8'h3f);
    rd(3'h1, 8'h00);
    // frame lock, then DATA0 on match
    wr(3'h4, 8'h01);
    put(1);
    wr(3'h1, 8'h07);
    eq.push_back(9'h1ff);
    eng.in_xfer(1, 0);
    eng.frame(1'b1);
    exp_pkt(1'b0);
    eng.in_xfer(1, 0);
    rd(3'h0, 8'h7f);
    eng.frame(1'b0);
    put(1);
    wr(3'h1, 8'h87);
    exp_pkt(1'b0);
    eng.in_xfer(1, 0);
    rd(3'h1, 8'h84);
    put(2);
    wr(3'h1, 8'h07);
    eng.frame(1'b1);
    eng.pulse('{sof: 1'b1, default: 1'b0});
    repeat (3) @(posedge mclk_i);
    rd(3'h0, 8'h3f);
    // saturated count, flags clear on read
    wr(3'h4, 8'h00);
    eng.rx('{good: 1'b1, pid1: 1'b1, default: 1'b0}, 7'd20);
    rd(3'h3, 8'h3f);
    rd(3'h3, 8'h0f);
    eng.rx('{good: 1'b1, zero_len: 1'b1, default: 1'b0}, 7'd0);
    eng.rx('{good: 1'b1, setup: 1'b1, default: 1'b0}, 7'd8);
    rd(3'h3, 8'h18);
    rd(3'h3, 8'h58);
    eng.rx('{err: 1'b1, default: 1'b0}, 7'd8);
    rd(3'h3, 8'h88);
    // Engine reports an empty receive FIFO, then isochronous toggle from the frame LSB
    eng.rx('{default: 1'b0}, 7'd0);
    rd(3'h3, 8'h00);
    wr(3'h4, 8'h01);
    eng.rx('{good: 1'b1, default: 1'b0}, 7'd8);
    rd(3'h3, 8'h38);
    repeat (4) @(posedge mclk_i);
    test_done;
  end
endmodule : tb

bind ude_endpoint_status ude_endpoint_status_sva #(.DEPTH_LOG2(DEPTH_LOG2)) chk (
  .mclk_i, .rst_n_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .tx_ev_i,
  .tx_ctl_o, .rx_level_i, .tx_low_warn_o);
